// File: rtl/fbsel_consts.svh
// Object indices, bit layout, preset values and timing for the fieldbus and script registers.
`ifndef FBSEL_CONSTS_SVH
`define FBSEL_CONSTS_SVH

`define OD_IDX_BUS_AVAIL 16'h2101
`define OD_IDX_BUS_CTRL 16'h2102
`define OD_IDX_BUS_STAT 16'h2103
`define OD_IDX_SCR_CTRL 16'h2300
`define OD_IDX_SCR_STAT 16'h2301
`define OD_IDX_SCR_ERR 16'h2302

`define OD_SUB_COUNT 8'h00
`define OD_SUB_MASK 8'h01
`define OD_SUB_ACTIVE 8'h02

// Bits 0..15 are physical interfaces, bits 16..31 are protocols.
`define PHY_FIELD_LSB 0
`define PHY_FIELD_MSB 15
`define PROTO_FIELD_LSB 16
`define PROTO_FIELD_MSB 31

`define USB_IFACE_BIT 0
`define RS485_IFACE_BIT 1
`define RS232_IFACE_BIT 2
`define CAN_IFACE_BIT 3
`define ETHERNET_IFACE_BIT 4
`define INDUSTRIAL_ETHERNET_BIT 5
`define SPI_IFACE_BIT 6
`define SERIAL_MODBUS_PROTO_BIT 16
`define TCP_MODBUS_PROTO_BIT 17
`define INDUSTRIAL_IP_PROTO_BIT 18

`define BUS_AVAIL_RESET 32'h0000_0018
`define BUS_CTRL_RESET 32'h0000_0018
`define BUS_STAT_ENTRIES 8'h02
`define BUS_SWITCH_MASK 32'h0000_0008
`define BUS_ACTIVE_RESET 32'h0000_0018
`define SCR_CTRL_RESET 32'h0000_0000
`define SCR_STAT_RESET 32'h0000_0000

`define SCR_RUN_CTRL_BIT 0
`define SCR_RUNNING_BIT 0
`define SCR_ERROR_BIT 2
`define SCR_ERR_LOAD_TIMEOUT 32'h0001_000F

`define SCR_START_MS 200
`define CLK_KHZ 100000
`define SCR_START_CYC (`SCR_START_MS * `CLK_KHZ)

`endif

// File: rtl/fbsel_pkg.sv
// Types shared by the fieldbus select and script control modules.
package fbsel_pkg;
    typedef logic [31:0] od_word_t;
    typedef enum logic [1:0] {S_IDLE, S_LOAD, S_RUN, S_FAULT} script_state_t;
endpackage : fbsel_pkg

// File: rtl/script_if.sv
// Signals between the register bank and the script sequencer.
`timescale 1ns/1ns
interface script_if;
    logic run_bit;
    logic load_done;
    logic fault;
    logic [31:0] fault_code;
    logic running;
    logic errored;
    logic [31:0] err_code;
    logic reload;
    logic clear_vars;
    logic exec;
    modport ctrl (
        output run_bit, load_done, fault, fault_code,
        input running, errored, err_code, reload, clear_vars, exec
    );
    modport seq (
        input run_bit, load_done, fault, fault_code,
        output running, errored, err_code, reload, clear_vars, exec
    );
endinterface : script_if

// File: rtl/script_sequencer.sv
// Script start, reload, run and fault sequencing.
`timescale 1ns/1ns
`include "fbsel_consts.svh"
module script_sequencer import fbsel_pkg::*; #(
    parameter int unsigned LOAD_WAIT_CYC = `SCR_START_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    script_if.seq sif
);
    script_state_t state_r, state_nxt;
    logic run_prev_r;
    logic run_rise;
    logic [24:0] load_cnt_r;
    logic load_timeout;
    logic reload_r, clear_vars_r, exec_r, errored_r;
    logic [31:0] err_code_r;

    assign run_rise = sif.run_bit && !run_prev_r;
    assign load_timeout = load_cnt_r == 25'(LOAD_WAIT_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            S_IDLE, S_FAULT: begin
                if (run_rise) begin
                    state_nxt = S_LOAD;
                end
            end
            S_LOAD: begin
                if (!sif.run_bit) begin
                    state_nxt = S_IDLE;
                end else if (sif.load_done) begin
                    state_nxt = S_RUN;
                end else if (load_timeout) begin
                    state_nxt = S_FAULT;
                end
            end
            S_RUN: begin
                if (!sif.run_bit) begin
                    state_nxt = S_IDLE;
                end else if (sif.fault) begin
                    state_nxt = S_FAULT;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= S_IDLE;
            run_prev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            run_prev_r <= sif.run_bit;
        end
    end

    // The load wait gives up so a missing loader cannot hang the start forever.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            load_cnt_r <= 25'h0000000;
        end else if (state_r == S_LOAD) begin
            load_cnt_r <= load_cnt_r + 25'h0000001;
        end else begin
            load_cnt_r <= 25'h0000000;
        end
    end

    // Reload and variable clear are one-cycle pulses on entry to loading.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reload_r <= 1'b0;
            clear_vars_r <= 1'b0;
            exec_r <= 1'b0;
        end else begin
            reload_r <= state_r != S_LOAD && state_nxt == S_LOAD;
            clear_vars_r <= state_r != S_LOAD && state_nxt == S_LOAD;
            exec_r <= state_nxt == S_RUN;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            errored_r <= 1'b0;
            err_code_r <= 32'h0000_0000;
        end else if (state_r == S_RUN && state_nxt == S_FAULT) begin
            errored_r <= 1'b1;
            err_code_r <= sif.fault_code;
        end else if (state_r == S_LOAD && state_nxt == S_FAULT) begin
            errored_r <= 1'b1;
            err_code_r <= `SCR_ERR_LOAD_TIMEOUT;
        end else if (state_nxt == S_LOAD && state_r != S_LOAD) begin
            errored_r <= 1'b0;
            err_code_r <= 32'h0000_0000;
        end
    end

    assign sif.reload = reload_r;
    assign sif.clear_vars = clear_vars_r;
    assign sif.exec = exec_r;
    assign sif.running = exec_r;
    assign sif.errored = errored_r;
    assign sif.err_code = err_code_r;

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_start;
        (state_r == S_IDLE || state_r == S_FAULT) && run_rise;
    endsequence
    sequence s_reload;
        reload_r && clear_vars_r && !exec_r && !errored_r;
    endsequence

    property p_start;
        @(posedge sys_clk_i) disable iff (!rstn_i) s_start |=> s_reload;
    endproperty
    a_start: assert property (p_start) else $error("start did not reload");

    property p_stop;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            !sif.run_bit && state_r != S_FAULT |=> !exec_r && !sif.running;
    endproperty
    a_stop: assert property (p_stop) else $error("script kept running");

    property p_run;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            state_r == S_LOAD && sif.run_bit && sif.load_done |=> sif.running [*1];
    endproperty
    a_run: assert property (p_run) else $error("script did not start");

    property p_fault;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            state_r == S_RUN && sif.run_bit && sif.fault
            |=> errored_r && !exec_r && err_code_r == $past(sif.fault_code);
    endproperty
    a_fault: assert property (p_fault) else $error("fault not reported");
endmodule : script_sequencer

// File: rtl/fieldbus_select_and_script_control.sv
// Object dictionary register bank for fieldbus selection and user script control.
// Functional notes
// - Bits 0 to 15 of the bus words are physical interfaces and bits 16 to 31 are protocols.
// - All four bus words share one bit layout, USB at bit 0 up to the IP protocol at bit 18.
// - The availability word shows a one for each fitted interface and cannot be written.
// - The bus control word is readable and writable and its bits switch buses on or off.
// - The switchable mask is read only and marks the buses that may be switched off.
// - The active word is read only and shows the buses that are both fitted and switched on now.
// - Subindex 0 of the status array reads as the 8-bit count two and is read only.
// - The script runs while control bit 0 is one, until it faults, and stops while it is zero.
// - A rising edge of control bit 0 first reloads the script and clears its variables.
// - The script status word is read only and shows the script's operating state.
// - The running flag of the status word is one while the script executes.
// - The error flag is set when the script ends with a fault, with the code readable.
`timescale 1ns/1ns
`include "fbsel_consts.svh"
module fieldbus_select_and_script_control import fbsel_pkg::*; #(
    parameter int unsigned LOAD_WAIT_CYC = `SCR_START_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic od_req_i,
    input wire logic od_wr_i,
    input wire logic [15:0] od_index_i,
    input wire logic [7:0] od_subindex_i,
    input wire logic [31:0] od_wdata_i,
    output logic od_ack_o,
    output logic od_abort_o,
    output logic [31:0] od_rdata_o,
    input wire logic [31:0] fitted_i,
    output logic [31:0] bus_enable_o,
    input wire logic script_loaded_i,
    input wire logic script_fault_i,
    input wire logic [31:0] script_fault_code_i,
    output logic script_reload_o,
    output logic script_clear_vars_o,
    output logic script_exec_o
);
    script_if sif ();

    od_word_t fitted_meta_r, fitted_sync_r;
    od_word_t avail_r;
    od_word_t ctrl_r;
    od_word_t active_r;
    logic scr_run_r;
    od_word_t scr_stat;
    od_word_t rd_val;
    logic rd_hit, wr_hit;
    logic take_wr;
    logic ack_r, abort_r;
    od_word_t rdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Presence straps are asynchronous pins and are synchronised first.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fitted_meta_r <= `BUS_AVAIL_RESET;
            fitted_sync_r <= `BUS_AVAIL_RESET;
        end else begin
            fitted_meta_r <= fitted_i;
            fitted_sync_r <= fitted_meta_r;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            avail_r <= `BUS_AVAIL_RESET;
        end else begin
            avail_r <= fitted_sync_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode of the object dictionary entries.
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
        wr_hit = 1'b0;
        unique case (od_index_i)
            `OD_IDX_BUS_AVAIL: begin
                rd_hit = od_subindex_i == `OD_SUB_COUNT;
                rd_val = avail_r;
            end
            `OD_IDX_BUS_CTRL: begin
                rd_hit = od_subindex_i == `OD_SUB_COUNT;
                wr_hit = od_subindex_i == `OD_SUB_COUNT;
                rd_val = ctrl_r;
            end
            `OD_IDX_BUS_STAT: begin
                rd_hit = od_subindex_i <= `OD_SUB_ACTIVE;
                if (od_subindex_i == `OD_SUB_COUNT) begin
                    rd_val = {24'h000000, `BUS_STAT_ENTRIES};
                end else if (od_subindex_i == `OD_SUB_MASK) begin
                    rd_val = `BUS_SWITCH_MASK;
                end else begin
                    rd_val = active_r;
                end
            end
            `OD_IDX_SCR_CTRL: begin
                rd_hit = od_subindex_i == `OD_SUB_COUNT;
                wr_hit = od_subindex_i == `OD_SUB_COUNT;
                rd_val = {31'h00000000, scr_run_r};
            end
            `OD_IDX_SCR_STAT: begin
                rd_hit = od_subindex_i == `OD_SUB_COUNT;
                rd_val = scr_stat;
            end
            `OD_IDX_SCR_ERR: begin
                rd_hit = od_subindex_i == `OD_SUB_COUNT;
                rd_val = sif.err_code;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    assign take_wr = od_req_i && od_wr_i && wr_hit;

    // Every request is answered on the next edge; writes to read-only or absent entries abort.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_r <= 1'b0;
            abort_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= od_req_i;
            abort_r <= od_req_i && (od_wr_i ? !wr_hit : !rd_hit);
            if (od_req_i && !od_wr_i && rd_hit) begin
                rdata_r <= rd_val;
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus activation: only switchable bits follow the written value.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= `BUS_CTRL_RESET;
        end else if (take_wr && od_index_i == `OD_IDX_BUS_CTRL) begin
            ctrl_r <= (od_wdata_i & `BUS_SWITCH_MASK) | (ctrl_r & ~`BUS_SWITCH_MASK);
        end
    end

    // A bus is active only when it is fitted and switched on.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            active_r <= `BUS_ACTIVE_RESET;
        end else begin
            active_r <= ctrl_r & avail_r;
        end
    end

    assign bus_enable_o = active_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Script control word holds only the run bit; other bits read as zero.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scr_run_r <= 1'(`SCR_CTRL_RESET);
        end else if (take_wr && od_index_i == `OD_IDX_SCR_CTRL) begin
            scr_run_r <= od_wdata_i[`SCR_RUN_CTRL_BIT];
        end
    end

    always_comb begin
        scr_stat = `SCR_STAT_RESET;
        scr_stat[`SCR_RUNNING_BIT] = sif.running;
        scr_stat[`SCR_ERROR_BIT] = sif.errored;
    end

    assign sif.run_bit = scr_run_r;
    assign sif.load_done = script_loaded_i;
    assign sif.fault = script_fault_i;
    assign sif.fault_code = script_fault_code_i;

    script_sequencer #(
        .LOAD_WAIT_CYC(LOAD_WAIT_CYC)
    ) u_seq (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .sif(sif.seq)
    );

    assign script_reload_o = sif.reload;
    assign script_clear_vars_o = sif.clear_vars;
    assign script_exec_o = sif.exec;
    assign od_ack_o = ack_r;
    assign od_abort_o = abort_r;
    assign od_rdata_o = rdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_rd(logic [15:0] idx, logic [7:0] sub);
        od_req_i && !od_wr_i && od_index_i == idx && od_subindex_i == sub;
    endsequence

    property p_avail_ro;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            od_req_i && od_wr_i && od_index_i == `OD_IDX_BUS_AVAIL
            |=> od_ack_o && od_abort_o && avail_r == $past(fitted_sync_r);
    endproperty
    a_avail_ro: assert property (p_avail_ro) else $error("availability write not refused");

    property p_avail_rd;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            s_rd(`OD_IDX_BUS_AVAIL, `OD_SUB_COUNT) |=> od_ack_o && od_rdata_o == $past(avail_r);
    endproperty
    a_avail_rd: assert property (p_avail_rd) else $error("availability read wrong");

    property p_ctrl_wr;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            od_req_i && od_wr_i && od_index_i == `OD_IDX_BUS_CTRL && od_subindex_i == 8'h00
            |=> !od_abort_o
            && ctrl_r == (($past(od_wdata_i) & `BUS_SWITCH_MASK)
            | ($past(ctrl_r) & ~`BUS_SWITCH_MASK));
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write wrong");

    property p_active;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            ##1 bus_enable_o == ($past(ctrl_r) & $past(avail_r));
    endproperty
    a_active: assert property (p_active) else $error("active word wrong");

    property p_count;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            s_rd(`OD_IDX_BUS_STAT, `OD_SUB_COUNT) |=> od_rdata_o == 32'h0000_0002 && !od_abort_o;
    endproperty
    a_count: assert property (p_count) else $error("entry count wrong");

    property p_mask;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            s_rd(`OD_IDX_BUS_STAT, `OD_SUB_MASK) |=> od_rdata_o == 32'h0000_0008;
    endproperty
    a_mask: assert property (p_mask) else $error("switchable mask wrong");

    property p_status;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            s_rd(`OD_IDX_SCR_STAT, `OD_SUB_COUNT)
            |=> od_rdata_o[0] == $past(sif.running) && od_rdata_o[2] == $past(sif.errored);
    endproperty
    a_status: assert property (p_status) else $error("script status wrong");

    property p_start_out;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            $rose(script_reload_o) |-> script_clear_vars_o && !script_exec_o;
    endproperty
    a_start_out: assert property (p_start_out) else $error("reload without clear");

    property p_proto_field;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            od_req_i && od_wr_i && od_index_i == `OD_IDX_BUS_CTRL
            |=> ctrl_r[`PROTO_FIELD_MSB:`PROTO_FIELD_LSB]
            == $past(ctrl_r[`PROTO_FIELD_MSB:`PROTO_FIELD_LSB]);
    endproperty
    a_proto_field: assert property (p_proto_field) else $error("protocol field switched");

    property p_can_bit;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            od_req_i && od_wr_i && od_index_i == `OD_IDX_BUS_CTRL
            && od_subindex_i == `OD_SUB_COUNT
            |=> ctrl_r[`CAN_IFACE_BIT] == $past(od_wdata_i[`CAN_IFACE_BIT])
            && ctrl_r[`USB_IFACE_BIT] == $past(ctrl_r[`USB_IFACE_BIT]);
    endproperty
    a_can_bit: assert property (p_can_bit) else $error("bus bit layout wrong");

    property p_ctrl_rd;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            s_rd(`OD_IDX_BUS_CTRL, `OD_SUB_COUNT)
            |=> od_ack_o && !od_abort_o && od_rdata_o == $past(ctrl_r);
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read wrong");

    property p_active_rd;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            s_rd(`OD_IDX_BUS_STAT, `OD_SUB_ACTIVE)
            |=> !od_abort_o && od_rdata_o == $past(active_r);
    endproperty
    a_active_rd: assert property (p_active_rd) else $error("active word read wrong");

    property p_run_rd;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            s_rd(`OD_IDX_SCR_CTRL, `OD_SUB_COUNT)
            |=> !od_abort_o && od_rdata_o == {31'h0, $past(scr_run_r)};
    endproperty
    a_run_rd: assert property (p_run_rd) else $error("run bit read wrong");

    property p_err_rd;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            s_rd(`OD_IDX_SCR_ERR, `OD_SUB_COUNT)
            |=> !od_abort_o && od_rdata_o == $past(sif.err_code);
    endproperty
    a_err_rd: assert property (p_err_rd) else $error("error code read wrong");

    property p_stat_ro;
        @(posedge sys_clk_i) disable iff (!rstn_i)
            od_req_i && od_wr_i && od_index_i == `OD_IDX_SCR_STAT
            |=> od_ack_o && od_abort_o && od_rdata_o == 32'h0000_0000;
    endproperty
    a_stat_ro: assert property (p_stat_ro) else $error("status write not refused");
endmodule : fieldbus_select_and_script_control

// File: test/tb_fieldbus_select_and_script_control.sv
// Self-checking testbench for the fieldbus select and script control register bank.
`timescale 1ns/1ns
`include "fbsel_consts.svh"
module tb_fieldbus_select_and_script_control import fbsel_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic od_req_i = 1'b0;
    logic od_wr_i = 1'b0;
    logic [15:0] od_index_i = 16'h0000;
    logic [7:0] od_subindex_i = 8'h00;
    od_word_t od_wdata_i = 32'h0000_0000;
    logic od_ack_o;
    logic od_abort_o;
    od_word_t od_rdata_o;
    od_word_t fitted_i = 32'h0000_0018;
    od_word_t bus_enable_o;
    logic script_loaded_i = 1'b0;
    logic script_fault_i = 1'b0;
    od_word_t script_fault_code_i = 32'h0000_0000;
    logic script_reload_o;
    logic script_clear_vars_o;
    logic script_exec_o;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 32;
    od_word_t ctrl_model;
    od_word_t wval;
    od_word_t code;
    int bit_pos [10] = '{0, 1, 2, 3, 4, 5, 6, 16, 17, 18};
    logic [15:0] ro_idx [4] = '{16'h2101, 16'h2103, 16'h2301, 16'h2302};

    fieldbus_select_and_script_control #(.LOAD_WAIT_CYC(20)) i_dut (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .od_req_i(od_req_i), .od_wr_i(od_wr_i),
        .od_index_i(od_index_i), .od_subindex_i(od_subindex_i), .od_wdata_i(od_wdata_i),
        .od_ack_o(od_ack_o), .od_abort_o(od_abort_o), .od_rdata_o(od_rdata_o),
        .fitted_i(fitted_i), .bus_enable_o(bus_enable_o), .script_loaded_i(script_loaded_i),
        .script_fault_i(script_fault_i), .script_fault_code_i(script_fault_code_i),
        .script_reload_o(script_reload_o), .script_clear_vars_o(script_clear_vars_o),
        .script_exec_o(script_exec_o)
    );

    always #5 sys_clk_i = ~sys_clk_i;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic od_word_t exp_ctrl(input od_word_t old, input od_word_t w);
        return (w & `BUS_SWITCH_MASK) | (old & ~`BUS_SWITCH_MASK);
    endfunction : exp_ctrl

    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task automatic chk_word(input od_word_t got, input od_word_t exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    // One access: request held for one edge, answer sampled after the next edge.
    task automatic od_acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input od_word_t wd, output od_word_t rd, output logic ab);
        @(posedge sys_clk_i);
        #1;
        od_req_i = 1'b1;
        od_wr_i = wr;
        od_index_i = idx;
        od_subindex_i = sub;
        od_wdata_i = wd;
        @(posedge sys_clk_i);
        #1;
        od_req_i = 1'b0;
        rd = od_rdata_o;
        ab = od_abort_o;
        chk_bit(od_ack_o, 1'b1);
    endtask : od_acc

    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] sub, input od_word_t exp,
                          input logic exp_ab);
        od_word_t rd;
        logic ab;
        od_acc(1'b0, idx, sub, 32'h0000_0000, rd, ab);
        chk_bit(ab, exp_ab);
        chk_word(rd, exp);
    endtask : rd_chk

    task automatic wr_chk(input logic [15:0] idx, input od_word_t wd, input logic exp_ab);
        od_word_t rd;
        logic ab;
        od_acc(1'b1, idx, 8'h00, wd, rd, ab);
        chk_bit(ab, exp_ab);
    endtask : wr_chk

    task automatic wait_exec(input logic v);
        for (int i = 0; i < 8 && script_exec_o !== v; i++) begin
            @(posedge sys_clk_i);
            #1;
        end
        chk_bit(script_exec_o, v);
    endtask : wait_exec

    // Raise the run bit from zero, check the reload pulse and optionally let loading finish.
    task automatic start_script(input logic load);
        wr_chk(`OD_IDX_SCR_CTRL, 32'hFFFF_FFFF, 1'b0);
        @(posedge sys_clk_i);
        #1;
        chk_bit(script_reload_o, 1'b1);
        chk_bit(script_clear_vars_o, 1'b1);
        chk_bit(script_exec_o, 1'b0);
        @(posedge sys_clk_i);
        #1;
        chk_bit(script_reload_o, 1'b0);
        if (load) begin
            script_loaded_i = 1'b1;
            wait_exec(1'b1);
            script_loaded_i = 1'b0;
        end
    endtask : start_script

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        err_total++;
        summarize();
    end

    initial begin
        repeat (8) @(posedge sys_clk_i);
        #1;
        rstn_i = 1'b1;
        chk_word(bus_enable_o, `BUS_ACTIVE_RESET);
        rd_chk(`OD_IDX_BUS_AVAIL, 8'h00, `BUS_AVAIL_RESET, 1'b0);
        rd_chk(`OD_IDX_BUS_CTRL, 8'h00, `BUS_CTRL_RESET, 1'b0);
        rd_chk(`OD_IDX_BUS_STAT, 8'h00, 32'h0000_0002, 1'b0);
        rd_chk(`OD_IDX_BUS_STAT, 8'h01, 32'h0000_0008, 1'b0);
        rd_chk(`OD_IDX_BUS_STAT, 8'h02, 32'h0000_0018, 1'b0);
        rd_chk(`OD_IDX_SCR_CTRL, 8'h00, 32'h0000_0000, 1'b0);
        rd_chk(`OD_IDX_SCR_STAT, 8'h00, 32'h0000_0000, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr_chk(ro_idx[i], $random(seed), 1'b1);
        end
        rd_chk(`OD_IDX_BUS_AVAIL, 8'h00, 32'h0000_0018, 1'b0);
        rd_chk(`OD_IDX_BUS_STAT, 8'h01, 32'h0000_0008, 1'b0);
        rd_chk(`OD_IDX_SCR_STAT, 8'h00, 32'h0000_0000, 1'b0);
        rd_chk(16'h2104, 8'h00, 32'h0000_0000, 1'b1);
        rd_chk(`OD_IDX_BUS_STAT, 8'h03, 32'h0000_0000, 1'b1);
        for (int i = 0; i < 10; i++) begin
            fitted_i = 32'h0000_0001 << bit_pos[i];
            repeat (5) @(posedge sys_clk_i);
            rd_chk(`OD_IDX_BUS_AVAIL, 8'h00, 32'h0000_0001 << bit_pos[i], 1'b0);
        end
        ctrl_model = `BUS_CTRL_RESET;
        for (int i = 0; i < 8; i++) begin
            fitted_i = (i < 2) ? 32'hFFFF_FFFF : $random(seed);
            wval = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'hFFFF_FFFF : $random(seed);
            wr_chk(`OD_IDX_BUS_CTRL, wval, 1'b0);
            ctrl_model = exp_ctrl(ctrl_model, wval);
            repeat (5) @(posedge sys_clk_i);
            #1;
            chk_word(bus_enable_o, ctrl_model & fitted_i);
            rd_chk(`OD_IDX_BUS_AVAIL, 8'h00, fitted_i, 1'b0);
            rd_chk(`OD_IDX_BUS_CTRL, 8'h00, ctrl_model, 1'b0);
            rd_chk(`OD_IDX_BUS_STAT, 8'h02, ctrl_model & fitted_i, 1'b0);
        end
        start_script(1'b1);
        rd_chk(`OD_IDX_SCR_CTRL, 8'h00, 32'h0000_0001, 1'b0);
        rd_chk(`OD_IDX_SCR_STAT, 8'h00, 32'h0000_0001, 1'b0);
        wr_chk(`OD_IDX_SCR_CTRL, 32'h0000_0000, 1'b0);
        wait_exec(1'b0);
        rd_chk(`OD_IDX_SCR_STAT, 8'h00, 32'h0000_0000, 1'b0);
        start_script(1'b1);
        code = $random(seed);
        script_fault_code_i = code;
        script_fault_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        script_fault_i = 1'b0;
        wait_exec(1'b0);
        rd_chk(`OD_IDX_SCR_STAT, 8'h00, 32'h0000_0004, 1'b0);
        rd_chk(`OD_IDX_SCR_ERR, 8'h00, code, 1'b0);
        wr_chk(`OD_IDX_SCR_CTRL, 32'h0000_0001, 1'b0);
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk_bit(script_exec_o, 1'b0);
        rd_chk(`OD_IDX_SCR_STAT, 8'h00, 32'h0000_0004, 1'b0);
        wr_chk(`OD_IDX_SCR_CTRL, 32'h0000_0000, 1'b0);
        start_script(1'b1);
        rd_chk(`OD_IDX_SCR_STAT, 8'h00, 32'h0000_0001, 1'b0);
        wr_chk(`OD_IDX_SCR_CTRL, 32'h0000_0000, 1'b0);
        wait_exec(1'b0);
        start_script(1'b0);
        repeat (30) @(posedge sys_clk_i);
        #1;
        chk_bit(script_exec_o, 1'b0);
        rd_chk(`OD_IDX_SCR_STAT, 8'h00, 32'h0000_0004, 1'b0);
        rd_chk(`OD_IDX_SCR_ERR, 8'h00, `SCR_ERR_LOAD_TIMEOUT, 1'b0);
        summarize();
    end
endmodule : tb_fieldbus_select_and_script_control
